//--- tlb_user_xlate.sv
// user-segment virtual to physical translator with register port
`timescale 1ns/1ps
`default_nettype none
module tlb_user_xlate (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [tlb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tlb_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [tlb_pkg::DATA_W-1:0] regRdData,
  input wire logic reqValid,
  input wire logic [tlb_pkg::VA_W-1:0] reqVaddr,
  input wire logic reqWrite,
  output logic rspValid,
  output logic rspHit,
  output logic [tlb_pkg::PA_W-1:0] rspPaddr,
  output logic [2:0] rspCacheAttr,
  output logic rspMiss,
  output logic rspWideRefill,
  output logic rspAddrErr,
  output logic rspInvalid,
  output logic rspModified,
  output logic rspUnmapped,
  output logic irq
);
  import tlb_pkg::*;

  // odd/even page select bit follows the entry's page size
  function automatic logic oddSelect(input logic [MASK_W-1:0] m,
                                     input logic [VA_W-1:0] va);
    logic r;
    r = va[12];
    case (m)
      12'h003: r = va[14];
      12'h00f: r = va[16];
      12'h03f: r = va[18];
      12'h0ff: r = va[20];
      12'h3ff: r = va[22];
      12'hfff: r = va[24];
      default: r = va[12];
    endcase
    return r;
  endfunction

  // software-visible state
  logic [TAG_W-1:0] tagAsid;
  logic [4:0] privStatus;
  logic [IDX_W-1:0] entryIndex;
  logic [MASK_W-1:0] stageMask;
  logic [VPN2_W-1:0] stageVpn2;
  logic [LO_W-1:0] stageEven;
  logic [LO_W-1:0] stageOdd;
  logic [EV_W-1:0] evStatus;
  logic [EV_W-1:0] evEnable;

  // translation table, flops so every entry compares at once
  logic [VPN2_W-1:0] entVpn2 [ENTRIES];
  logic [MASK_W-1:0] entMask [ENTRIES];
  logic [TAG_W-1:0] entAsid [ENTRIES];
  logic [LO_W-1:0] entEven [ENTRIES];
  logic [LO_W-1:0] entOdd [ENTRIES];
  logic [ENTRIES-1:0] entG;
  logic [ENTRIES-1:0] entPresent;
  logic [ENTRIES-1:0] hitVec;

  logic commit;
  assign commit = regWr && (regAddr == OFS_ENTRY_COMMIT);

  // privilege decode
  logic userMode;
  logic wideMode;
  assign userMode = (privStatus[PRIV_LSB +: 2] == PRIV_USER) &&
                    !privStatus[EXL_BIT] && !privStatus[ERL_BIT];
  assign wideMode = privStatus[WIDE_BIT];

  // segment bounds
  logic signExtOk;
  logic inSeg32;
  logic inSeg64;
  logic inSeg;
  assign signExtOk = (reqVaddr[63:32] == {32{reqVaddr[31]}});
  // unsigned-looking addresses are treated as out of segment, not guessed
  assign inSeg32 = signExtOk && !reqVaddr[31];
  assign inSeg64 = (reqVaddr[63:40] == 24'h000000);
  assign inSeg = wideMode ? inSeg64 : inSeg32;

  // lookup key: upper page bits only exist in 64-bit mode
  logic [VPN2_W-1:0] keyVpn2;
  assign keyVpn2 = wideMode ? reqVaddr[39:13] :
                   {8'h00, reqVaddr[31:13]};

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : gEntry
      logic vpnEq;
      // masked bits widen the offset and shrink the page number
      assign vpnEq = ((keyVpn2 ^ entVpn2[gi]) &
                      ~{15'h0000, entMask[gi]}) == '0;
      assign hitVec[gi] = entPresent[gi] && vpnEq &&
                          (entG[gi] || entAsid[gi] == tagAsid);

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          entVpn2[gi] <= '0;
          entMask[gi] <= '0;
          entAsid[gi] <= '0;
          entEven[gi] <= '0;
          entOdd[gi] <= '0;
          entG[gi] <= 1'b0;
          entPresent[gi] <= 1'b0;
        end else if (commit && entryIndex == IDX_W'(gi)) begin
          entVpn2[gi] <= stageVpn2;
          entMask[gi] <= stageMask;
          entAsid[gi] <= tagAsid;
          entEven[gi] <= stageEven;
          entOdd[gi] <= stageOdd;
          // match-all only when both halves agree
          entG[gi] <= stageEven[LO_G_BIT] && stageOdd[LO_G_BIT];
          entPresent[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // several matches are undefined; lowest index simply wins
  logic anyHit;
  logic [IDX_W-1:0] hitIdx;
  always_comb begin
    anyHit = 1'b0;
    hitIdx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        anyHit = 1'b1;
        hitIdx = IDX_W'(i);
      end
    end
  end

  // frame selection and physical address forming
  logic [MASK_W-1:0] selMask;
  logic [LO_W-1:0] selLo;
  logic [PA_W-1:0] offMask;
  logic [PA_W-1:0] pageBase;
  logic [PA_W-1:0] next_paddr;
  assign selMask = entMask[hitIdx];
  assign selLo = oddSelect(selMask, reqVaddr) ? entOdd[hitIdx] :
                 entEven[hitIdx];
  assign offMask = {8'h00, selMask, 12'hfff};
  assign pageBase = {selLo[LO_PFN_LSB +: PFN_W], 12'h000};
  assign next_paddr = (pageBase & ~offMask) |
                      (reqVaddr[PA_W-1:0] & offMask);

  logic loValid;
  logic loDirty;
  assign loValid = selLo[LO_V_BIT];
  assign loDirty = selLo[LO_D_BIT];

  // classification of this request
  logic doMap;
  logic next_addrErr;
  logic next_miss;
  logic next_invalid;
  logic next_modified;
  logic next_hit;
  assign next_addrErr = reqValid && userMode && !inSeg;
  assign doMap = reqValid && inSeg;
  assign next_miss = doMap && !anyHit;
  assign next_invalid = doMap && anyHit && !loValid;
  assign next_modified = doMap && anyHit && loValid &&
                         reqWrite && !loDirty;
  assign next_hit = doMap && anyHit && loValid &&
                    !(reqWrite && !loDirty);

  // response stage, one cycle after the request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rspValid <= 1'b0;
      rspHit <= 1'b0;
      rspPaddr <= '0;
      rspCacheAttr <= '0;
      rspMiss <= 1'b0;
      rspWideRefill <= 1'b0;
      rspAddrErr <= 1'b0;
      rspInvalid <= 1'b0;
      rspModified <= 1'b0;
      rspUnmapped <= 1'b0;
    end else begin
      rspValid <= reqValid;
      rspHit <= next_hit;
      // faulting references never show an address
      rspPaddr <= next_hit ? next_paddr : '0;
      rspCacheAttr <= next_hit ? selLo[LO_C_LSB +: 3] : 3'h0;
      rspMiss <= next_miss;
      rspWideRefill <= next_miss && wideMode;
      rspAddrErr <= next_addrErr;
      rspInvalid <= next_invalid;
      rspModified <= next_modified;
      // outside user segment in higher privilege is handled elsewhere
      rspUnmapped <= reqValid && !userMode && !inSeg;
    end
  end

  // register writes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tagAsid <= RST_TAG;
      privStatus <= RST_PRIV;
      entryIndex <= '0;
      stageMask <= '0;
      stageVpn2 <= '0;
      stageEven <= '0;
      stageOdd <= '0;
      evEnable <= RST_EV;
    end else if (regWr) begin
      if (regAddr == OFS_TAG_ENTRY) begin
        tagAsid <= regWrData[TAG_W-1:0];
      end else if (regAddr == OFS_PRIV_STATUS) begin
        privStatus <= regWrData[4:0];
      end else if (regAddr == OFS_ENTRY_INDEX) begin
        entryIndex <= regWrData[IDX_W-1:0];
      end else if (regAddr == OFS_ENTRY_MASK) begin
        stageMask <= regWrData[MASK_LSB +: MASK_W];
      end else if (regAddr == OFS_ENTRY_VPN2) begin
        stageVpn2 <= regWrData[VPN2_W-1:0];
      end else if (regAddr == OFS_FRAME_EVEN) begin
        stageEven <= regWrData[LO_W-1:0];
      end else if (regAddr == OFS_FRAME_ODD) begin
        stageOdd <= regWrData[LO_W-1:0];
      end else if (regAddr == OFS_EVENT_ENABLE) begin
        evEnable <= regWrData[EV_W-1:0];
      end
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;
  logic [EV_W-1:0] next_evStatus;
  assign evSet = {next_modified, next_invalid, next_addrErr, next_miss};
  assign evClr = (regWr && regAddr == OFS_EVENT_CLEAR) ?
                 regWrData[EV_W-1:0] : 4'h0;
  assign next_evStatus = (evStatus & ~evClr) | evSet;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      evStatus <= RST_EV;
    end else begin
      evStatus <= next_evStatus;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_evStatus & evEnable);
    end
  end

  // read data, valid only in the cycle after the read strobe
  logic [DATA_W-1:0] next_rdData;
  always_comb begin
    next_rdData = '0;
    if (regAddr == OFS_TAG_ENTRY) begin
      next_rdData = {24'h000000, tagAsid};
    end else if (regAddr == OFS_PRIV_STATUS) begin
      next_rdData = {27'h0000000, privStatus};
    end else if (regAddr == OFS_ENTRY_INDEX) begin
      next_rdData = {27'h0000000, entryIndex};
    end else if (regAddr == OFS_ENTRY_MASK) begin
      next_rdData = {7'h00, stageMask, 13'h0000};
    end else if (regAddr == OFS_ENTRY_VPN2) begin
      next_rdData = {5'h00, stageVpn2};
    end else if (regAddr == OFS_FRAME_EVEN) begin
      next_rdData = {6'h00, stageEven};
    end else if (regAddr == OFS_FRAME_ODD) begin
      next_rdData = {6'h00, stageOdd};
    end else if (regAddr == OFS_EVENT_STATUS) begin
      next_rdData = {28'h0000000, evStatus};
    end else if (regAddr == OFS_EVENT_ENABLE) begin
      next_rdData = {28'h0000000, evEnable};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= '0;
    end
  end
endmodule
`default_nettype wire

//--- tlb_pkg.sv
// constants and register map for the user-segment address translator
// Overview of operation
// - lookup key is the address extended with the 8-bit tag from tag_entry_reg
// - hit needs equal page number and either match-all bit or equal tag
// - no matching entry raises a translation miss event
// - physical address is matched frame number joined with untouched offset
// - physical addresses are 32 bits wide, a four gigabyte space
// - 32-bit mode, 4K pages: 12-bit offset, 20-bit page number
// - 32-bit mode, 16M pages: 24-bit offset, 8-bit page number
// - 64-bit mode, 4K pages: 12-bit offset, 28-bit page number
// - 64-bit mode, 16M pages: 24-bit offset, 16-bit page number
// - user privilege only when privilege field is 10, both level bits clear
// - wide-user bit picks 32-bit or 64-bit user segment and refill handler
// - 32-bit user addressing faults any address with top bit set
// - 64-bit user addressing faults any address with bits 63:40 nonzero
// - user segment always goes through the table; entry sets cacheability
// - 32-bit addresses are valid only when bits 63:32 copy bit 31
// - 32 fully associative entries of even/odd page pairs, compared at once
// - page sizes 4K to 16M in steps of four; split follows the size
// - single hit yields cache, writable, valid; bad bits raise modify/invalid
package tlb_pkg;
  localparam int ENTRIES = 32;
  localparam int IDX_W = 5;
  localparam int VA_W = 64;
  localparam int PA_W = 32;
  localparam int TAG_W = 8;
  localparam int VPN2_W = 27;
  localparam int MASK_W = 12;
  localparam int PFN_W = 20;
  localparam int LO_W = 26;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EV_W = 4;

  // register byte offsets
  localparam logic [7:0] OFS_TAG_ENTRY = 8'h00;
  localparam logic [7:0] OFS_PRIV_STATUS = 8'h04;
  localparam logic [7:0] OFS_ENTRY_INDEX = 8'h08;
  localparam logic [7:0] OFS_ENTRY_MASK = 8'h0c;
  localparam logic [7:0] OFS_ENTRY_VPN2 = 8'h10;
  localparam logic [7:0] OFS_FRAME_EVEN = 8'h14;
  localparam logic [7:0] OFS_FRAME_ODD = 8'h18;
  localparam logic [7:0] OFS_ENTRY_COMMIT = 8'h1c;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h20;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'h24;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h28;

  // privilege status field positions
  localparam int PRIV_LSB = 0;
  localparam int EXL_BIT = 2;
  localparam int ERL_BIT = 3;
  localparam int WIDE_BIT = 4;
  localparam logic [1:0] PRIV_USER = 2'h2;

  // frame word layout
  localparam int LO_PFN_LSB = 6;
  localparam int LO_C_LSB = 3;
  localparam int LO_D_BIT = 2;
  localparam int LO_V_BIT = 1;
  localparam int LO_G_BIT = 0;

  // entry mask sits at address bits 24:13
  localparam int MASK_LSB = 13;

  // event bits
  localparam int EV_MISS = 0;
  localparam int EV_ADDR_ERR = 1;
  localparam int EV_INVALID = 2;
  localparam int EV_MODIFIED = 3;

  // reset values
  localparam logic [7:0] RST_TAG = 8'h00;
  localparam logic [4:0] RST_PRIV = 5'h00;
  localparam logic [3:0] RST_EV = 4'h0;
endpackage

//--- tlb_xlate_checker.sv
// port-level assertions for the user-segment translator
`timescale 1ns/1ps
`default_nettype none
module tlb_xlate_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic regRd,
  input wire logic [tlb_pkg::DATA_W-1:0] regRdData,
  input wire logic reqValid,
  input wire logic [tlb_pkg::VA_W-1:0] reqVaddr,
  input wire logic rspValid,
  input wire logic rspHit,
  input wire logic [tlb_pkg::PA_W-1:0] rspPaddr,
  input wire logic [2:0] rspCacheAttr,
  input wire logic rspMiss,
  input wire logic rspWideRefill,
  input wire logic rspAddrErr,
  input wire logic rspInvalid,
  input wire logic rspModified,
  input wire logic rspUnmapped
);
  import tlb_pkg::*;
  logic [5:0] flags;
  assign flags = {rspHit, rspMiss, rspAddrErr, rspInvalid, rspModified,
                  rspUnmapped};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_ans; reqValid |=> rspValid; endproperty
  a_ans: assert property (p_ans)
    else $error("request left unanswered");
  property p_quiet; !reqValid |=> !rspValid && flags == 6'h00; endproperty
  a_quiet: assert property (p_quiet)
    else $error("response without request");
  property p_one; rspValid |-> $onehot(flags); endproperty
  a_one: assert property (p_one)
    else $error("not exactly one result flag");
  property p_off;
    reqValid |=> !rspHit || rspPaddr[11:0] == $past(reqVaddr[11:0]);
  endproperty
  a_off: assert property (p_off)
    else $error("offset altered by translation");
  property p_inseg;
    reqValid && reqVaddr[63:31] == 33'h0 |=> !rspAddrErr && !rspUnmapped;
  endproperty
  a_inseg: assert property (p_inseg)
    else $error("in-segment address not translated");
  property p_err; rspAddrErr |-> rspPaddr == 32'h0 && !rspHit; endproperty
  a_err: assert property (p_err)
    else $error("address presented on address error");
  property p_wide; rspWideRefill |-> rspMiss; endproperty
  a_wide: assert property (p_wide)
    else $error("wide refill without miss");
  property p_nohit;
    !rspHit |-> rspPaddr == 32'h0 && rspCacheAttr == 3'h0;
  endproperty
  a_nohit: assert property (p_nohit)
    else $error("address or attribute without hit");
  property p_rd; !regRd |=> regRdData == 32'h0; endproperty
  a_rd: assert property (p_rd)
    else $error("read data outside its cycle");
endmodule
bind tlb_user_xlate tlb_xlate_checker u_chk (.ref_clk, .reset, .regRd,
  .regRdData, .reqValid, .reqVaddr, .rspValid, .rspHit, .rspPaddr,
  .rspCacheAttr, .rspMiss, .rspWideRefill, .rspAddrErr, .rspInvalid,
  .rspModified, .rspUnmapped);
`default_nettype wire

//--- tlb_req_model.sv
// pipeline model issuing translation requests
`timescale 1ns/1ps
`default_nettype none
module tlb_req_model (
  input wire logic ref_clk,
  output logic reqValid,
  output logic [tlb_pkg::VA_W-1:0] reqVaddr,
  output logic reqWrite
);
  import tlb_pkg::*;
  initial begin
    reqValid = 1'b0;
    reqVaddr = '0;
    reqWrite = 1'b0;
  end
  task automatic issue(input logic [VA_W-1:0] va, input logic w);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqVaddr <= va;
    reqWrite <= w;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    // idle lines inverted so no stale address can pass for valid
    reqVaddr <= ~va;
    reqWrite <= ~w;
  endtask
endmodule
`default_nettype wire

//--- tlb_user_mode_translation_tb.sv
// self-checking bench for the user-segment translator
`timescale 1ns/1ps
`default_nettype none
module tlb_user_mode_translation_tb;
  import tlb_pkg::*;
  localparam logic [6:0] H = 7'h40, MS = 7'h20, AE = 7'h10, IV = 7'h08;
  localparam logic [6:0] MD = 7'h04, UM = 7'h02, WR = 7'h01;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic reqValid, reqWrite, rspValid, rspHit, rspMiss, rspWideRefill;
  logic rspAddrErr, rspInvalid, rspModified, rspUnmapped, irq;
  logic [VA_W-1:0] reqVaddr, va;
  logic [PA_W-1:0] rspPaddr;
  logic [2:0] rspCacheAttr;
  int n_mismatch = 0;
  int checked = 0;
  integer seed;
  always #20 ref_clk = ~ref_clk;
  tlb_req_model u_cpu (.ref_clk, .reqValid, .reqVaddr, .reqWrite);
  tlb_user_xlate dut (.ref_clk, .reset, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .reqValid, .reqVaddr, .reqWrite, .rspValid,
    .rspHit, .rspPaddr, .rspCacheAttr, .rspMiss, .rspWideRefill,
    .rspAddrErr, .rspInvalid, .rspModified, .rspUnmapped, .irq);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  function automatic logic [31:0] fr(input logic [19:0] pfn,
    input logic [2:0] c, input logic dw, input logic v, input logic g);
    return {6'h00, pfn, c, dw, v, g};
  endfunction
  task automatic ent(input logic [4:0] i, input logic [11:0] m,
    input logic [26:0] vpn2, input logic [31:0] lo0, input logic [31:0] lo1);
    wr(OFS_ENTRY_INDEX, {27'h0, i});
    wr(OFS_ENTRY_MASK, {7'h0, m, 13'h0});
    wr(OFS_ENTRY_VPN2, {5'h0, vpn2});
    wr(OFS_FRAME_EVEN, lo0);
    wr(OFS_FRAME_ODD, lo1);
    wr(OFS_ENTRY_COMMIT, 32'h0);
  endtask
  // answer lands one edge after the request edge
  task automatic xl(input logic [63:0] a, input logic w, input logic [6:0] f,
    input logic [31:0] pa, input logic [2:0] c);
    u_cpu.issue(a, w);
    #1 chk({rspValid, rspHit, rspMiss, rspAddrErr, rspInvalid, rspModified,
      rspUnmapped, rspWideRefill}, {1'b1, f});
    chk({rspCacheAttr, rspPaddr}, {c, pa});
  endtask
  task automatic summarize;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize;
  end
  initial begin
    seed = 36;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    wr(OFS_EVENT_ENABLE, 32'hf);
    wr(OFS_PRIV_STATUS, 32'h2);
    ent(0, 12'h0, 27'h0, fr(20'h55, 3'h3, 1, 1, 0), fr(20'h66, 3'h2, 1, 0, 0));
    wr(OFS_TAG_ENTRY, 32'h5);
    ent(1, 12'h0, 27'h2, fr(20'h77, 3'h1, 0, 1, 1), fr(20'h88, 3'h1, 0, 1, 1));
    ent(2, 12'hfff, 27'h1000, fr(20'hab000, 3'h4, 1, 1, 0),
      fr(20'hcd000, 3'h4, 1, 1, 0));
    xl(64'h1234, 0, MS, 0, 0);
    rd(OFS_EVENT_STATUS, 32'h1);
    chk(irq, 1'b1);
    wr(OFS_EVENT_CLEAR, 32'hf);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    xl(64'h4010, 1, MD, 0, 0);
    xl(64'h5010, 0, H, 32'h00088010, 3'h1);
    xl(64'h02123456, 0, H, 32'hab123456, 3'h4);
    xl(64'h03000010, 1, H, 32'hcd000010, 3'h4);
    wr(OFS_TAG_ENTRY, 32'h0);
    // bit 12 clear picks the even half of the 4K pair
    xl(64'h0234, 0, H, 32'h00055234, 3'h3);
    xl(64'h1abc, 0, IV, 0, 0);
    xl(64'h0234, 1, H, 32'h00055234, 3'h3);
    xl(64'hffffffff80000000, 0, AE, 0, 0);
    xl(64'h100001234, 0, AE, 0, 0);
    wr(OFS_PRIV_STATUS, 32'h12);
    xl(64'hfffffff000, 0, MS | WR, 0, 0);
    xl(64'h10000000000, 0, AE, 0, 0);
    xl(64'h0234, 0, H, 32'h00055234, 3'h3);
    // the 16M entry was committed under tag 5
    wr(OFS_TAG_ENTRY, 32'h5);
    xl(64'h02123456, 0, H, 32'hab123456, 3'h4);
    for (int i = 0; i < 16; i++) begin
      va = {$random(seed), $random(seed)};
      va[39:36] = 4'hf;
      if (i[0])
        va[63:40] = 24'h0;
      xl(va, i[1], (va[63:40] != 0) ? AE : (MS | WR), 0, 0);
    end
    wr(OFS_PRIV_STATUS, 32'h6);
    xl(64'hffffffff80000000, 0, UM, 0, 0);
    wr(OFS_PRIV_STATUS, 32'h0);
    xl(64'h5010, 0, H, 32'h00088010, 3'h1);
    wr(OFS_EVENT_CLEAR, 32'hf);
    wr(OFS_EVENT_STATUS, 32'hf);
    rd(OFS_EVENT_STATUS, 32'h0);
    rd(OFS_EVENT_ENABLE, 32'hf);
    rd(OFS_ENTRY_COMMIT, 32'h0);
    rd(8'h30, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
